// *** verilog/timer_pkg.sv ***
// Purpose: shared constants and types for the pwm / pulse / capture timer
// Assumes: 16-bit counter, 16-bit register data, one system clock
// Notes:   register offsets are word indices on the plain register port
package timer_pkg;

  // widths
  localparam int CNT_W  = 16;           // counter and compare_a width
  localparam int CMPP_W = 8;            // compare_p holds the upper byte
  localparam int ADDR_W = 3;            // register index width
  localparam int CTRL_W = 9;            // used bits of the control word

  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CMP_A  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CMP_P  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 3'h4;

  // status bit positions, write one to clear
  localparam int STAT_A_BIT = 0;
  localparam int STAT_P_BIT = 1;

  // reset values
  localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0]  CMPA_RESET = 16'h0000;
  localparam logic [CMPP_W-1:0] CMPP_RESET = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // full 16-bit span, used when a compare value reads zero
  localparam logic [CNT_W:0] SPAN_FULL = 17'h1_0000;
  localparam logic [CNT_W:0] ONE_17    = 17'h0_0001;
  // compare_p is scaled by 256: low byte of the target is zero
  localparam logic [7:0]     P_LOW_BYTE = 8'h00;

  // operating mode
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } op_mode_t;

  // pin action; in capture mode the same codes pick the edge:
  // 00 rising, 01 falling, 10 both, 11 capture disabled
  typedef enum logic [1:0] {
    PIN_INACTIVE = 2'b00,
    PIN_ACTIVE   = 2'b01,
    PIN_PWM      = 2'b10,
    PIN_PULSE    = 2'b11
  } pin_action_t;

  // control word, msb first, as written at ADDR_CTRL
  typedef struct packed {
    logic        timer_run;
    op_mode_t    op_mode_sel;
    pin_action_t pin_action_sel;
    logic        output_level_ctrl;
    logic        output_invert;
    logic        duty_period_swap;
    logic        clear_source_sel;
  } timer_ctrl_one_t;

  // pin event pulses from the synchroniser
  typedef struct packed {
    logic rise;
    logic fall;
  } pin_edge_t;

  // counts to reach a compare value; zero stands for the full span
  function automatic logic [CNT_W:0] span_of(input logic [CNT_W-1:0] val);
    span_of = (val == CNT_RESET) ? SPAN_FULL : {1'b0, val};
  endfunction : span_of

endpackage : timer_pkg

// *** verilog/pin_edge_sync.sv ***
// Purpose: bring an outside pin into the clock domain and flag its edges
// Assumes: pin is asynchronous to clk_sys_i
// Notes:   edges appear two clock edges after the pin moves
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sync (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // raw pin
  input  wire logic                 pin_i,
  // edge pulses, one cycle each
  output var timer_pkg::pin_edge_t  edge_o
);

  logic meta;   // first stage, read only by sync
  logic sync;   // second stage, safe to use
  logic last;   // previous synced level for edge detect

  // two-stage synchroniser plus history flop
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  // edge decode from the safe stages only
  assign edge_o.rise = sync & ~last;
  assign edge_o.fall = ~sync & last;

endmodule : pin_edge_sync
`default_nettype wire

// *** verilog/timer_pwm_pulse_capture.sv ***
// Purpose: 16-bit timer with pwm output, single pulse and input capture
// Assumes: counter ticks on every clk_sys_i edge while running
// Notes:   registers on a plain port; read data one cycle after the strobe
//
// Functional notes
// - pwm: one compare sets period, other duty
// - pwm ignores clear_source_sel
// - pwm flags a and p matches separately
// - level ctrl picks polarity; pin action forces
// - output_invert flips the driven pin
// - swap 0: period p*256 or 65536
// - duty at or above period: always active
// - swap 1: period a, duty p*256
// - counter runs while pin is forced
// - pulse mode: pwm mode plus action 11
// - trigger pin rising edge sets timer_run
// - run rise starts counter and leading edge
// - a match or software clear ends pulse
// - pulse mode a match raises flag
// - pulse counter zeroed only on run rise
// - capture mode 01, started by run rise
// - capture edge latches counter into compare_a
// - capture counter free runs until stopped
// - capture p match clears counter, flags
// - capture edge code 11 disables capture
// - capture mode drives no output
// - capture edge codes: rise, fall, both
// - pwm selected by mode 10, action 10
// - action codes: inactive, active, pwm, pulse
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_pulse_capture #(
  parameter int CNT_W = timer_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          nrst_i,

  // register port
  input  wire logic [timer_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [CNT_W-1:0]              wr_data_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [CNT_W-1:0]              rd_data_o,

  // outside pins
  input  wire logic                          pulse_trigger_pin_i,
  input  wire logic                          capture_input_pin_i,
  output logic                               timer_output_pin_o,

  // sticky match flags, also readable in status
  output logic                               match_a_flag_o,
  output logic                               match_p_flag_o
);

  // the logic below is written for exactly the documented width
  if (CNT_W != timer_pkg::CNT_W) begin : g_width_check
    $error("timer counter width must be 16");
  end

  // programmable state
  timer_pkg::timer_ctrl_one_t       ctrl;         // control word
  logic [CNT_W-1:0]                 cmp_a;        // compare_a_value
  logic [timer_pkg::CMPP_W-1:0]     cmp_p;        // compare_p_value

  // running state
  logic [CNT_W-1:0]                 cnt;          // main up-counter
  logic                             next_run;     // run bit after this edge

  // synchronised pin edges
  timer_pkg::pin_edge_t             trig_edge;    // pulse trigger pin
  timer_pkg::pin_edge_t             cap_edge;     // capture input pin

  // decoded helpers
  logic                             run_rise;     // run went low to high
  logic                             mode_cap;     // capture mode
  logic                             mode_out;     // pwm family of modes
  logic                             mode_pulse;   // single pulse mode
  logic [CNT_W:0]                   cnt_next;     // count plus one, 17 bit
  logic [CNT_W:0]                   a_span;       // counts to compare a
  logic [CNT_W:0]                   p_span;       // counts to compare p*256
  logic                             a_hit;        // comparator a match
  logic                             p_hit;        // comparator p match
  logic [CNT_W:0]                   period_span;  // pwm period in counts
  logic [CNT_W:0]                   duty_span;    // pwm duty in counts
  logic                             period_hit;   // pwm period end
  logic                             pwm_active;   // pwm waveform, active high
  logic                             cap_event;    // capture edge qualified
  logic                             wave_active;  // chosen active state
  logic                             next_pin;     // pin level before flop
  logic                             set_a;        // raise flag a
  logic                             set_p;        // raise flag p
  logic                             clr_a;        // software clears flag a
  logic                             clr_p;        // software clears flag p
  logic                             wr_ctrl;      // write to control word

  // pin synchronisers, two flops before any use
  pin_edge_sync u_trig_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .pin_i     (pulse_trigger_pin_i),
    .edge_o    (trig_edge)
  );

  pin_edge_sync u_cap_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .pin_i     (capture_input_pin_i),
    .edge_o    (cap_edge)
  );

  // mode decode
  assign mode_cap   = (ctrl.op_mode_sel == timer_pkg::MODE_CAPTURE);
  assign mode_out   = (ctrl.op_mode_sel == timer_pkg::MODE_PWM);
  // pulse needs both codes; software must not move the action bits
  assign mode_pulse = mode_out && (ctrl.pin_action_sel == timer_pkg::PIN_PULSE);
  // start seen a cycle early, so the count clears as run sets
  assign run_rise   = next_run && !ctrl.timer_run;
  assign wr_ctrl    = wr_i && (addr_i == timer_pkg::ADDR_CTRL);

  // comparators: a hit means the next count reaches the compare value
  // so the clear lands exactly on the span edge
  assign cnt_next = {1'b0, cnt} + timer_pkg::ONE_17;
  assign a_span   = timer_pkg::span_of(cmp_a);
  assign p_span   = timer_pkg::span_of({cmp_p, timer_pkg::P_LOW_BYTE});
  assign a_hit    = (cnt_next == a_span);
  assign p_hit    = (cnt_next == p_span);

  // pwm roles follow the swap bit; clear_source_sel is not looked at
  // swapping while running gives one odd period
  always_comb begin
    if (ctrl.duty_period_swap) begin
      period_span = a_span;
      duty_span   = p_span;
      period_hit  = a_hit;
    end else begin
      period_span = p_span;
      duty_span   = a_span;
      period_hit  = p_hit;
    end
  end

  // active while below duty; duty not below period holds it active
  // spans are 17 bit, so zero means 65536 counts
  assign pwm_active = ({1'b0, cnt} < duty_span) || (duty_span >= period_span);

  // capture edge select
  // edges lag the pin by the synchroniser
  always_comb begin
    unique case (ctrl.pin_action_sel)
      timer_pkg::PIN_INACTIVE: cap_event = cap_edge.rise;
      timer_pkg::PIN_ACTIVE:   cap_event = cap_edge.fall;
      timer_pkg::PIN_PWM:      cap_event = cap_edge.rise | cap_edge.fall;
      timer_pkg::PIN_PULSE:    cap_event = 1'b0;
    endcase
  end

  // waveform choice; the counter keeps going when the pin is forced
  // pulse code follows run; the pin lags it a cycle
  always_comb begin
    unique case (ctrl.pin_action_sel)
      timer_pkg::PIN_INACTIVE: wave_active = 1'b0;
      timer_pkg::PIN_ACTIVE:   wave_active = 1'b1;
      timer_pkg::PIN_PWM:      wave_active = pwm_active;
      timer_pkg::PIN_PULSE:    wave_active = ctrl.timer_run;
    endcase
  end

  // active level from level ctrl, then optional inversion
  always_comb begin
    if (mode_out) begin
      next_pin = (wave_active ? ctrl.output_level_ctrl : !ctrl.output_level_ctrl)
                 ^ ctrl.output_invert;
    end else begin
      // capture and the unserved modes leave the pin low
      next_pin = 1'b0;
    end
  end

  // flag sources
  // only captures raise a flag while stopped
  always_comb begin
    set_a = 1'b0;
    set_p = 1'b0;
    if (mode_cap) begin
      set_a = cap_event;
      set_p = ctrl.timer_run && p_hit;
    end else if (mode_pulse) begin
      set_a = ctrl.timer_run && a_hit;
    end else if (mode_out) begin
      set_a = ctrl.timer_run && a_hit;
      set_p = ctrl.timer_run && p_hit;
    end else begin
      // compare and timer modes, kept minimal
      set_a = ctrl.timer_run && a_hit;
      set_p = ctrl.timer_run && p_hit && !ctrl.clear_source_sel;
    end
  end

  // software clear of status bits, write one to clear
  assign clr_a = wr_i && (addr_i == timer_pkg::ADDR_STATUS) && wr_data_i[timer_pkg::STAT_A_BIT];
  assign clr_p = wr_i && (addr_i == timer_pkg::ADDR_STATUS) && wr_data_i[timer_pkg::STAT_P_BIT];

  // next run bit: software write first, then hardware overrides;
  // worked out ahead so the counter clear lines up with the start
  always_comb begin
    next_run = ctrl.timer_run;
    if (wr_ctrl) begin
      // run is the msb of the control word
      next_run = wr_data_i[timer_pkg::CTRL_W-1];
    end
    // comparator a ends the pulse by stopping the timer
    if (mode_pulse && ctrl.timer_run && a_hit) begin
      next_run = 1'b0;
    end
    // trigger pin acts like a software set of run; it wins over a hit
    if (mode_pulse && trig_edge.rise) begin
      next_run = 1'b1;
    end
  end

  // control word; run bit always comes from next_run
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= timer_pkg::timer_ctrl_one_t'(timer_pkg::CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl <= timer_pkg::timer_ctrl_one_t'(wr_data_i[timer_pkg::CTRL_W-1:0]);
      end
      // hardware run changes override the same-cycle write
      ctrl.timer_run <= next_run;
    end
  end

  // compare_a: software value, or captured count in capture mode
  // capture works even while the counter is stopped
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_a <= timer_pkg::CMPA_RESET;
    end else if (mode_cap && cap_event) begin
      // capture wins over a write in the same cycle
      cmp_a <= cnt;
    end else if (wr_i && (addr_i == timer_pkg::ADDR_CMP_A)) begin
      cmp_a <= wr_data_i;
    end
  end

  // compare_p: upper byte of the period or duty
  // the low byte is always zero, so it is not stored
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_p <= timer_pkg::CMPP_RESET;
    end else if (wr_i && (addr_i == timer_pkg::ADDR_CMP_P)) begin
      cmp_p <= wr_data_i[timer_pkg::CMPP_W-1:0];
    end
  end

  // counter
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= timer_pkg::CNT_RESET;
    end else if (run_rise) begin
      // every start begins from zero
      cnt <= timer_pkg::CNT_RESET;
    end else if (!ctrl.timer_run) begin
      // stopped: hold so a read sees a still value
      cnt <= cnt;
    end else if (mode_pulse) begin
      // no clear source in pulse mode; a match stops it instead
      cnt <= cnt_next[CNT_W-1:0];
    end else if (mode_out && period_hit) begin
      // the duty compare only flags, never clears
      cnt <= timer_pkg::CNT_RESET;
    end else if (mode_cap && p_hit) begin
      // p zero spans the full range, so the count tops out there
      cnt <= timer_pkg::CNT_RESET;
    end else if (!mode_out && !mode_cap
                 && (ctrl.clear_source_sel ? a_hit : p_hit)) begin
      // compare and timer modes: software picks the source
      cnt <= timer_pkg::CNT_RESET;
    end else begin
      // free run; capture edges do not disturb it
      cnt <= cnt_next[CNT_W-1:0];
    end
  end

  // flag a, set wins over a clear in the same cycle
  // a lost clear is safer than a lost event
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_a_flag_o <= 1'b0;
    end else if (set_a) begin
      match_a_flag_o <= 1'b1;
    end else if (clr_a) begin
      match_a_flag_o <= 1'b0;
    end
  end

  // flag p, set wins over a clear in the same cycle
  // cleared only by writing one to its status bit
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_p_flag_o <= 1'b0;
    end else if (set_p) begin
      match_p_flag_o <= 1'b1;
    end else if (clr_p) begin
      match_p_flag_o <= 1'b0;
    end
  end

  // output pin, registered so it cannot glitch
  // low from reset until software picks a mode
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_output_pin_o <= 1'b0;
    end else begin
      timer_output_pin_o <= next_pin;
    end
  end

  // read port; data stands only in the cycle after the strobe
  // reads have no side effects on the flags
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= timer_pkg::CNT_RESET;
    end else if (rd_i) begin
      unique case (addr_i)
        timer_pkg::ADDR_CTRL:   rd_data_o <= CNT_W'(ctrl);
        timer_pkg::ADDR_CMP_A:  rd_data_o <= cmp_a;
        timer_pkg::ADDR_CMP_P:  rd_data_o <= CNT_W'(cmp_p);
        timer_pkg::ADDR_STATUS: rd_data_o <= CNT_W'({match_p_flag_o, match_a_flag_o});
        timer_pkg::ADDR_COUNT:  rd_data_o <= cnt;
        // unmapped addresses read as zero
        default:                rd_data_o <= timer_pkg::CNT_RESET;
      endcase
    end else begin
      rd_data_o <= timer_pkg::CNT_RESET;
    end
  end

endmodule : timer_pwm_pulse_capture
`default_nettype wire

// *** testbench/timer_pwm_pulse_capture_props.sv ***
// Purpose: port-level checks for the pwm / pulse / capture timer
// Assumes: ctrl bits [7:2] change only by register writes
// Notes:   pin events need about three cycles through the synchroniser
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_pulse_capture_props #(
  parameter int CNT_W = timer_pkg::CNT_W
) (
  // clock and reset
  input wire logic                         clk_sys_i,
  input wire logic                         nrst_i,
  // register port
  input wire logic [timer_pkg::ADDR_W-1:0] addr_i,
  input wire logic [CNT_W-1:0]             wr_data_i,
  input wire logic                         wr_i,
  input wire logic                         rd_i,
  input wire logic [CNT_W-1:0]             rd_data_o,
  // pins and flags
  input wire logic                         pulse_trigger_pin_i,
  input wire logic                         capture_input_pin_i,
  input wire logic                         timer_output_pin_o,
  input wire logic                         match_a_flag_o,
  input wire logic                         match_p_flag_o
);
  logic [5:0] sh;      // mode, action, level, invert
  logic [3:0] age;     // cycles since sh last changed
  logic       ctl_wr;  // control word write
  logic       clr_a;   // status clear of flag a
  logic       clr_p;   // status clear of flag p
  logic       lvl;     // pin level when active
  assign ctl_wr = wr_i && addr_i == timer_pkg::ADDR_CTRL;
  assign clr_a  = wr_i && addr_i == timer_pkg::ADDR_STATUS && wr_data_i[timer_pkg::STAT_A_BIT];
  assign clr_p  = wr_i && addr_i == timer_pkg::ADDR_STATUS && wr_data_i[timer_pkg::STAT_P_BIT];
  assign lvl    = sh[1] ^ sh[0];
  // shadow of software-only bits; run is left out since hardware moves it
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) sh <= '0;
    else if (ctl_wr) sh <= wr_data_i[7:2];
  end
  // age saturates so long idle spans stay valid
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) age <= '0;
    else if (ctl_wr && wr_data_i[7:2] != sh) age <= '0;
    else if (age != 4'hF) age <= age + 4'h1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_capture_no_out: assert property (sh[5:4] == 2'b01 && age != 0 |-> !timer_output_pin_o)
    else $error("output pin driven in capture mode");
  a_forced_low: assert property (sh[5:2] == 4'b1000 && age != 0 |-> timer_output_pin_o == !lvl)
    else $error("forced inactive level wrong");
  a_forced_high: assert property (sh[5:2] == 4'b1001 && age != 0 |-> timer_output_pin_o == lvl)
    else $error("forced active level wrong");
  a_capture_rise: assert property (
    sh[5:2] == 4'b0100 && age > 2 && $rose(capture_input_pin_i) |-> ##[1:6] match_a_flag_o)
    else $error("rising capture edge missed");
  a_capture_fall: assert property (
    sh[5:2] == 4'b0101 && age > 2 && $fell(capture_input_pin_i) |-> ##[1:6] match_a_flag_o)
    else $error("falling capture edge missed");
  a_capture_off: assert property (sh[5:2] == 4'b0111 && age > 4 |-> !$rose(match_a_flag_o))
    else $error("capture while disabled");
  a_pulse_lead: assert property (
    ctl_wr && wr_data_i[8] && wr_data_i[7:2] == sh && sh[5:2] == 4'b1011 && age != 0
    && timer_output_pin_o == !lvl |-> ##2 timer_output_pin_o == lvl)
    else $error("pulse leading edge late");
  a_trig_start: assert property (
    sh[5:2] == 4'b1011 && age > 3 && $rose(pulse_trigger_pin_i) && timer_output_pin_o == !lvl
    |-> ##[2:7] timer_output_pin_o == lvl)
    else $error("trigger did not start pulse");
  a_flag_a_hold: assert property ($fell(match_a_flag_o) |-> $past(clr_a))
    else $error("flag a dropped without clear");
  a_flag_p_hold: assert property ($fell(match_p_flag_o) |-> $past(clr_p))
    else $error("flag p dropped without clear");
  c_pulse: cover property (sh[5:2] == 4'b1011 && $rose(timer_output_pin_o));
  c_capture: cover property (sh[5:4] == 2'b01 && $rose(match_a_flag_o));
  c_p_match: cover property ($rose(match_p_flag_o));
endmodule : timer_pwm_pulse_capture_props
`default_nettype wire

// *** testbench/pin_source_model.sv ***
// Purpose: outside source for the capture input and pulse trigger pins
// Assumes: the testbench calls the tasks hierarchically
// Notes:   levels change just after a clock edge and then hold
`timescale 1ns/10ps
`default_nettype none
module pin_source_model (
  // clock
  input  wire logic clk_sys_i,
  // driven pins
  output var logic  trig_o,
  output var logic  cap_o
);
  // both pins idle low
  initial begin
    trig_o = 1'b0;
    cap_o  = 1'b0;
  end
  // capture source level, held until the next call
  task automatic drive_cap(input logic lvl);
    @(posedge clk_sys_i);
    cap_o <= lvl;
  endtask : drive_cap
  // held high long enough to cross the synchroniser
  task automatic fire_trig();
    @(posedge clk_sys_i);
    trig_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    trig_o <= 1'b0;
  endtask : fire_trig
endmodule : pin_source_model
`default_nettype wire

// *** testbench/test_timer_pwm_pulse_capture.sv ***
// Purpose: directed register-level test of the pwm / pulse / capture timer
// Assumes: 10 MHz clock, register port answers one cycle after the strobe
// Notes:   pwm duty is judged by counting high cycles over whole periods
`timescale 1ns/10ps
`default_nettype none
module test_timer_pwm_pulse_capture;
  logic [2:0]  addr_i;     // register index
  logic [15:0] wr_data_i;  // write data
  logic [15:0] rd_data_o;  // read data
  logic [15:0] v;          // last read value
  logic [15:0] c1;         // earlier count
  logic        clk_sys_i, nrst_i, wr_i, rd_i, trig, cap, pin_o, flag_a, flag_p;
  int          failures, checked, n;
  // ctrl, cmp_a, cmp_p, high cycles in 512
  localparam logic [15:0] PWM_TAB [7][4] = '{
    '{16'h01A8, 16'h0040, 16'h0001, 16'h0080}, '{16'h01AD, 16'h0040, 16'h0001, 16'h0180},
    '{16'h01A8, 16'h012C, 16'h0001, 16'h0200}, '{16'h01AA, 16'h0200, 16'h0001, 16'h0100},
    '{16'h01A0, 16'h0040, 16'h0001, 16'h0180}, '{16'h0188, 16'h0040, 16'h0001, 16'h0000},
    '{16'h0198, 16'h0040, 16'h0001, 16'h0200}};
  localparam logic [3:0] FALL_HIT = 4'h6;  // per edge code: fall captured
  localparam logic [3:0] RISE_HIT = 4'h5;  // per edge code: rise captured
  timer_pwm_pulse_capture uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .pulse_trigger_pin_i(trig), .capture_input_pin_i(cap), .timer_output_pin_o(pin_o),
    .match_a_flag_o(flag_a), .match_p_flag_o(flag_p));
  pin_source_model u_src (.clk_sys_i(clk_sys_i), .trig_o(trig), .cap_o(cap));
  // free-running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_sys_i);
    wr_i      <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 d = rd_data_o;
    @(posedge clk_sys_i);
  endtask : rd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask : rchk
  // sampled just after each edge, once the pin register has settled
  task automatic high_count(input int k);
    n = 0;
    repeat (k) begin
      @(posedge clk_sys_i);
      #1 if (pin_o === 1'b1) n++;
    end
  endtask : high_count
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    failures++;
    summarize();
  end
  initial begin
    {nrst_i, wr_i, rd_i, addr_i, wr_data_i, failures, checked} = '0;
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // reset values, unmapped index ignores writes
    wr(3'h5, 16'hFFFF);
    for (int i = 0; i < 6; i++) rchk(3'(i), 16'h0000);
    // pwm table: period, duty, level, invert, forced codes
    for (int r = 0; r < 7; r++) begin
      wr(timer_pkg::ADDR_CTRL, 16'h0000);
      wr(timer_pkg::ADDR_CMP_A, PWM_TAB[r][1]);
      wr(timer_pkg::ADDR_CMP_P, PWM_TAB[r][2]);
      wr(timer_pkg::ADDR_CTRL, PWM_TAB[r][0]);
      repeat (4) @(posedge clk_sys_i);
      high_count(512);
      chk(16'(n), PWM_TAB[r][3]);
    end
    chk({14'h0000, flag_p, flag_a}, 16'h0003);
    // counter still runs while forced, reads three cycles apart
    rd(timer_pkg::ADDR_COUNT, c1);
    rd(timer_pkg::ADDR_COUNT, v);
    chk({8'h00, 8'(v[7:0] - c1[7:0])}, 16'h0003);
    wr(timer_pkg::ADDR_CTRL, 16'h0098);
    rd(timer_pkg::ADDR_COUNT, c1);
    rchk(timer_pkg::ADDR_COUNT, c1);
    // single pulse, swap set but ignored
    wr(timer_pkg::ADDR_STATUS, 16'h0003);
    wr(timer_pkg::ADDR_CMP_A, 16'h0005);
    wr(timer_pkg::ADDR_CTRL, 16'h00BA);
    repeat (3) @(posedge clk_sys_i);
    wr(timer_pkg::ADDR_CTRL, 16'h01BA);
    high_count(20);
    chk(16'(n), 16'h0005);
    chk({15'h0000, flag_a}, 16'h0001);
    rchk(timer_pkg::ADDR_CTRL, 16'h00BA);
    rchk(timer_pkg::ADDR_COUNT, 16'h0005);
    // software ends a long pulse early
    wr(timer_pkg::ADDR_CMP_A, 16'h0064);
    wr(timer_pkg::ADDR_CTRL, 16'h01BA);
    high_count(5);
    chk(16'(n), 16'h0005);
    wr(timer_pkg::ADDR_CTRL, 16'h00BA);
    high_count(10);
    chk(16'(n), 16'h0000);
    // trigger pin starts the pulse
    wr(timer_pkg::ADDR_CMP_A, 16'h0005);
    repeat (3) @(posedge clk_sys_i);
    fork
      u_src.fire_trig();
      high_count(30);
    join
    chk(16'(n), 16'h0005);
    rchk(timer_pkg::ADDR_CTRL, 16'h00BA);
    // capture, p match wraps counter below 256, no output
    wr(timer_pkg::ADDR_STATUS, 16'h0003);
    wr(timer_pkg::ADDR_CTRL, 16'h014C);
    repeat (300) @(posedge clk_sys_i);
    chk({13'h0000, flag_a, flag_p, pin_o}, 16'h0002);
    rd(timer_pkg::ADDR_COUNT, v);
    chk(v & 16'hFF00, 16'h0000);
    // stopped counter gives an exact latch value
    wr(timer_pkg::ADDR_CTRL, 16'h004C);
    rd(timer_pkg::ADDR_COUNT, c1);
    u_src.drive_cap(1'b1);
    repeat (6) @(posedge clk_sys_i);
    rchk(timer_pkg::ADDR_CMP_A, c1);
    chk({15'h0000, flag_a}, 16'h0001);
    // every edge code, fall then rise
    for (int e = 0; e < 4; e++) begin
      wr(timer_pkg::ADDR_CTRL, 16'h004C | 16'(e << 4));
      wr(timer_pkg::ADDR_STATUS, 16'h0003);
      u_src.drive_cap(1'b0);
      repeat (6) @(posedge clk_sys_i);
      chk({15'h0000, flag_a}, {15'h0000, FALL_HIT[e]});
      wr(timer_pkg::ADDR_STATUS, 16'h0001);
      u_src.drive_cap(1'b1);
      repeat (6) @(posedge clk_sys_i);
      chk({15'h0000, flag_a}, {15'h0000, RISE_HIT[e]});
    end
    summarize();
  end
endmodule : test_timer_pwm_pulse_capture
bind timer_pwm_pulse_capture timer_pwm_pulse_capture_props #(.CNT_W(CNT_W)) u_props (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .pulse_trigger_pin_i(pulse_trigger_pin_i),
  .capture_input_pin_i(capture_input_pin_i), .timer_output_pin_o(timer_output_pin_o),
  .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
`default_nettype wire
